/* rtl/wml_top.sv */
// Marker output logic for the waveform playback engine.
// Assumes sample clock i_clk and synchronous preset on i_sys_rst.
`timescale 1ns/100ps
`include "wml_consts.svh"
module wml_top (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_play,
  input  wire logic                      i_gen_mode,
  input  wire logic                      i_seg_volatile,
  input  wire wml_pkg::wml_cmd_t         i_cmd,
  input  wire logic [`WML_AW-1:0]        i_cmd_addr,
  input  wire logic                      i_dl_we,
  input  wire logic [`WML_AW-1:0]        i_dl_addr,
  input  wire logic [`WML_DW-1:0]        i_dl_data,
  input  wire logic                      i_mk_edit,
  input  wire logic [1:0]                i_mk_chan,
  input  wire logic [`WML_AW-1:0]        i_mk_first,
  input  wire logic [`WML_AW-1:0]        i_mk_last,
  input  wire logic                      i_mk_on,
  input  wire logic [`WML_NMARK-1:0]     i_pol_neg,
  input  wire logic [`WML_NMARK-1:0]     i_mk_en,
  input  wire logic [1:0]                i_route [`WML_NMARK],
  input  wire logic                      i_cfg_we,
  input  wire logic                      i_seq_we,
  input  wire logic [`WML_SEQ_AW-1:0]    i_seq_idx,
  input  wire logic [`WML_REP_W-1:0]     i_seq_rep,
  input  wire logic                      i_seq_commit,
  input  wire logic                      i_seq_exit,
  input  wire logic [`WML_SEQ_AW-1:0]    i_seq_rd_idx,
  output logic      [`WML_REP_W-1:0]     o_seq_rep,
  output logic      [`WML_DW-1:0]        o_sample,
  output logic      [`WML_NMARK-1:0]     o_event,
  output logic                           o_hold,
  output logic                           o_blank,
  output logic      [`WML_DW-1:0]        o_level,
  output logic                           o_edit_refused,
  output logic                           o_busy
);
  typedef struct packed {
    wml_pkg::wml_state_t           st;
    logic [`WML_AW-1:0]            addr;
    logic [`WML_AW-1:0]            copy_lo;
    logic [`WML_AW-1:0]            copy_hi;
    logic                          to_nv;
    logic [`WML_NMARK-1:0]         init_mk;
    logic [`WML_AW-1:0]            play_addr;
    logic                          played;
    logic [`WML_NMARK-1:0]         pol;
    logic [`WML_NMARK-1:0][1:0]    route;
    logic [`WML_LAG-1:0][`WML_NMARK-1:0] dly_m;
    logic                          rd_v;
    logic [`WML_ACC_W-1:0]         acc;
    logic [`WML_AW:0]              cnt;
    logic [`WML_DW-1:0]            level;
    logic [`WML_NMARK-1:0]         ev;
    logic [`WML_DW-1:0]            smp;
    logic                          refused;
    logic [`WML_SEQ_N-1:0][`WML_REP_W-1:0] rep_live;
    logic [`WML_SEQ_N-1:0][`WML_REP_W-1:0] rep_edit;
  } wml_state_s_t;
  wml_state_s_t r;
  wml_state_s_t next_r;
  wml_mem_if    vol ();
  wml_mem_if    nv ();
  logic [`WML_NMARK-1:0] mk_raw;
  logic [`WML_NMARK-1:0] mk_sig;
  logic                  hold_any;
  logic                  blank_any;
  // Volatile store; cleared through the init path on an init command, not by preset
  wml_mem u_vol (
    .i_clk (i_clk),
    .bus   (vol.mem)
  );
  // Nonvolatile store: no init write, so it survives preset
  wml_mem u_nv (
    .i_clk (i_clk),
    .bus   (nv.mem)
  );
  // True when address lies in the inclusive marker range
  function automatic logic in_rng(input logic [`WML_AW-1:0] a, input logic [`WML_AW-1:0] lo,
                                  input logic [`WML_AW-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction
  // Markers come from memory beside the sample, then take polarity
  assign mk_raw = vol.rdata[`WML_DW+`WML_NMARK-1:`WML_DW];
  assign mk_sig = (mk_raw & i_mk_en) ^ r.pol;
  always_comb begin
    hold_any  = 1'b0;
    blank_any = 1'b0;
    for (int i = 0; i < `WML_NMARK; i++) begin
      if (r.rd_v && mk_sig[i] && r.route[i] != 2'(wml_pkg::WML_ROUTE_NONE)) begin
        hold_any = 1'b1;
      end
      if (r.rd_v && mk_sig[i] && r.route[i] == 2'(wml_pkg::WML_ROUTE_BLANK)) begin
        blank_any = 1'b1;
      end
    end
  end
  // Memory ports: copy engine owns both stores while busy
  always_comb begin
    vol.we    = 1'b0;
    vol.waddr = i_dl_addr;
    vol.wdata = {`WML_MK_NONE, i_dl_data};
    vol.raddr = r.play_addr;
    nv.we     = 1'b0;
    nv.waddr  = r.addr;
    nv.wdata  = vol.rdata;
    nv.raddr  = r.addr;
    case (r.st)
      wml_pkg::WML_INIT: begin
        vol.we    = 1'b1;
        vol.waddr = r.addr;
        vol.wdata = {(r.addr == '0) ? r.init_mk : `WML_MK_NONE, `WML_DW'h0000};
      end
      wml_pkg::WML_COPY_RD: begin
        vol.raddr = r.addr;
      end
      wml_pkg::WML_COPY_WR: begin
        vol.raddr = r.addr;
        nv.we     = r.to_nv;
        vol.we    = !r.to_nv;
        vol.waddr = r.addr;
        vol.wdata = nv.rdata;
      end
      default: begin
        if (i_dl_we) begin
          vol.we = 1'b1;
        end else if (i_mk_edit && !o_edit_refused) begin
          vol.we    = 1'b1;
          vol.waddr = r.play_addr;
          vol.wdata = vol.rdata;
          vol.wdata[`WML_DW+i_mk_chan] = in_rng(r.play_addr, i_mk_first, i_mk_last) ? i_mk_on :
                                         mk_raw[i_mk_chan];
        end
      end
    endcase
  end
  // Edits need a volatile segment, and in generated mode a prior play
  assign o_edit_refused = i_mk_edit && (!i_seg_volatile || (i_gen_mode && !r.played));
  assign o_busy         = r.st != wml_pkg::WML_IDLE;
  // Next-state logic for playback, copy engine and level loop
  always_comb begin
    next_r = r;
    next_r.refused = o_edit_refused;
    if (i_cfg_we) begin
      next_r.pol   = i_pol_neg;
      for (int i = 0; i < `WML_NMARK; i++) begin
        next_r.route[i] = i_route[i];
      end
    end
    if (i_seq_we) begin
      next_r.rep_edit[i_seq_idx] = i_seq_rep;
    end
    if (i_seq_commit) begin
      next_r.rep_live = r.rep_edit;
    end else if (i_seq_exit) begin
      next_r.rep_edit = r.rep_live;
    end
    // Playback steps through the segment; edits stay on the current word
    next_r.rd_v = i_play && r.st == wml_pkg::WML_IDLE;
    if (r.st == wml_pkg::WML_IDLE && i_play) begin
      next_r.play_addr = r.play_addr + `WML_AW'(1);
    end
    if (i_play) begin
      next_r.played = 1'b1;
    end
    // Marker path delayed so events trail the sample by the lag
    next_r.dly_m[0] = r.rd_v ? (mk_raw & i_mk_en) : `WML_MK_NONE;
    for (int k = 1; k < `WML_LAG; k++) begin
      next_r.dly_m[k] = r.dly_m[k-1];
    end
    next_r.smp = vol.rdata[`WML_DW-1:0];
    next_r.ev  = r.dly_m[`WML_LAG-1];
    // Level loop averages samples while the routed marker is high
    if (hold_any) begin
      if (!r.rd_v || r.cnt == '0) begin
        next_r.acc = '0;
      end
      next_r.acc = next_r.acc + `WML_ACC_W'(vol.rdata[`WML_DW-1:0]);
      next_r.cnt = r.cnt + (`WML_AW+1)'(1);
    end else if (r.cnt != '0) begin
      next_r.level = `WML_DW'(r.acc / `WML_ACC_W'(r.cnt));
      next_r.cnt   = '0;
    end
    // Store/load sequencer
    case (r.st)
      wml_pkg::WML_IDLE: begin
        next_r.addr    = '0;
        next_r.copy_lo = '0;
        next_r.copy_hi = '1;
        case (i_cmd)
          wml_pkg::WML_CMD_INIT_GEN:  begin next_r.st = wml_pkg::WML_INIT; next_r.init_mk = `WML_MK_GEN; end
          wml_pkg::WML_CMD_INIT_DL:   begin next_r.st = wml_pkg::WML_INIT; next_r.init_mk = `WML_MK_NONE; end
          wml_pkg::WML_CMD_INIT_FACT: begin next_r.st = wml_pkg::WML_INIT; next_r.init_mk = `WML_MK_FACT; end
          wml_pkg::WML_CMD_STORE_ALL: begin next_r.st = wml_pkg::WML_COPY_RD; next_r.to_nv = 1'b1; end
          wml_pkg::WML_CMD_LOAD_ALL:  begin next_r.st = wml_pkg::WML_COPY_RD; next_r.to_nv = 1'b0; end
          wml_pkg::WML_CMD_STORE_ONE, wml_pkg::WML_CMD_LOAD_ONE: begin
            next_r.st      = wml_pkg::WML_COPY_RD;
            next_r.to_nv   = i_cmd == wml_pkg::WML_CMD_STORE_ONE;
            next_r.addr    = i_cmd_addr;
            next_r.copy_lo = i_cmd_addr;
            next_r.copy_hi = i_cmd_addr;
          end
          default: ;
        endcase
      end
      wml_pkg::WML_INIT: begin
        next_r.addr = r.addr + `WML_AW'(1);
        if (r.addr == '1) begin
          next_r.st = wml_pkg::WML_IDLE;
        end
      end
      wml_pkg::WML_COPY_RD: begin
        next_r.st = wml_pkg::WML_COPY_WR;
      end
      wml_pkg::WML_COPY_WR: begin
        next_r.addr = r.addr + `WML_AW'(1);
        next_r.st   = (r.addr == r.copy_hi) ? wml_pkg::WML_IDLE : wml_pkg::WML_COPY_RD;
      end
      default: next_r.st = wml_pkg::WML_IDLE;
    endcase
  end
  // Preset returns settings to defaults
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.rep_live <= {`WML_SEQ_N{`WML_REP_W'h0001}};
      r.rep_edit <= {`WML_SEQ_N{`WML_REP_W'h0001}};
    end else begin
      r <= next_r;
    end
  end
  assign o_sample  = r.smp;
  assign o_event   = r.ev;
  assign o_hold    = hold_any;
  assign o_blank   = blank_any;
  assign o_level   = r.level;
  assign o_seq_rep = r.rep_live[i_seq_rd_idx];
  // Event pulse follows the sample it marks by the lag
  a_event_lag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    r.rd_v |-> ##3 o_event == $past(mk_raw & i_mk_en, 3)) else $error("event lag check");
  a_no_marks_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !r.rd_v |-> ##3 o_event == '0) else $error("event not low without play");
  a_blank_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_blank |-> o_hold) else $error("blank without hold");
  a_edit_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_mk_edit && !i_seg_volatile) |-> o_edit_refused) else $error("edit on nonvolatile");
  a_gen_play: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_mk_edit && i_seg_volatile && i_gen_mode && !r.played) |-> o_edit_refused) else $error("gen edit early");
  a_pol_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_cfg_we |=> r.pol == $past(r.pol)) else $error("polarity drifted");
  a_exit_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_seq_exit && !i_seq_commit) |=> r.rep_edit == r.rep_live) else $error("edit kept");
  a_copy_ends: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (r.st == wml_pkg::WML_COPY_WR && r.addr == r.copy_hi) |=> r.st == wml_pkg::WML_IDLE) else $error("copy overrun");
endmodule

/* pkg/wml_consts.svh */
// Constants for the waveform marker output logic.
// Assumes it is included by bare name from package and design files.
//
// What this block does
// - Four marker channels per stored sample
// - Enabled marker point drives matching event output
// - Markers route to level hold or blanking
// - Generated segment: first sample, markers 1-2
// - Download without markers: all markers empty
// - Factory segment: first sample, all markers
// - Edits only while segment is volatile
// - Generated-format mode: edit only after play
// - Polarity and routing persist until reset
// - Hold freezes level at sampled average
// - Sample level while marker signal high
// - Marker output lags waveform two samples
// - Repetition counts editable, unstored edits dropped
// - Volatile store cleared by init commands, not by reset; nonvolatile kept
// - Store-all, load-all and single copies
// - No marker points keeps output low
// - Negative polarity inverts marker signal for hold and blanking, not event outputs
`ifndef WML_CONSTS_SVH
`define WML_CONSTS_SVH
`define WML_NMARK       4
`define WML_AW          8
`define WML_DW          16
`define WML_DEPTH       256
`define WML_SEQ_N       16
`define WML_SEQ_AW      4
`define WML_REP_W       16
`define WML_LAG         2
`define WML_ACC_W       32
`define WML_MK_GEN      4'h3
`define WML_MK_FACT     4'hF
`define WML_MK_NONE     4'h0
`endif

/* pkg/wml_pkg.sv */
// Types for the waveform marker output logic.
// Assumes wml_consts.svh is on the include path.
`include "wml_consts.svh"
package wml_pkg;
  typedef enum logic [2:0] {
    WML_CMD_NONE,
    WML_CMD_INIT_GEN,
    WML_CMD_INIT_DL,
    WML_CMD_INIT_FACT,
    WML_CMD_STORE_ALL,
    WML_CMD_LOAD_ALL,
    WML_CMD_STORE_ONE,
    WML_CMD_LOAD_ONE
  } wml_cmd_t;
  typedef enum logic [1:0] {
    WML_ROUTE_NONE,
    WML_ROUTE_HOLD,
    WML_ROUTE_BLANK
  } wml_route_t;
  typedef enum {
    WML_IDLE,
    WML_INIT,
    WML_COPY_RD,
    WML_COPY_WR
  } wml_state_t;
endpackage

/* pkg/wml_mem_if.sv */
// Port bundle between the marker core and its sample memories.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`include "wml_consts.svh"
interface wml_mem_if;
  logic                        we;
  logic [`WML_AW-1:0]          waddr;
  logic [`WML_DW+`WML_NMARK-1:0] wdata;
  logic [`WML_AW-1:0]          raddr;
  logic [`WML_DW+`WML_NMARK-1:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* rtl/wml_mem.sv */
// Sample plus marker memory with registered read data.
// Assumes one clock; contents are not cleared by reset.
`timescale 1ns/100ps
`include "wml_consts.svh"
module wml_mem (
  input  wire logic  i_clk,
  wml_mem_if.mem     bus
);
  logic [`WML_DW+`WML_NMARK-1:0] mem [`WML_DEPTH];
  // Read data registered, so markers leave in step with the sample word
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.raddr];
  end
endmodule

/* verification/wml_event_listener.sv */
// Behavioural test instrument that listens to the four marker event outputs.
// Assumes the event lines come from the marker block on the same sample clock.
`timescale 1ns/100ps
`include "wml_consts.svh"
module wml_event_listener (
  input  wire logic                  i_clk,
  input  wire logic                  i_clear,
  input  wire logic [`WML_NMARK-1:0] i_event,
  output int                         o_pulses [`WML_NMARK]
);
  logic [`WML_NMARK-1:0] last_ev;

  // Count rising edges per channel; a channel without marker points never pulses
  always @(posedge i_clk) begin
    for (int k = 0; k < `WML_NMARK; k++) begin
      if (i_clear) begin
        o_pulses[k] <= 0;
      end else if (i_event[k] === 1'h1 && last_ev[k] === 1'h0) begin
        o_pulses[k] <= o_pulses[k] + 1;
      end
    end
    // Clear keeps the present level so a line left high is not counted twice
    last_ev <= i_event;
  end
endmodule

/* verification/waveform_marker_output_logic_test.sv */
// Self-checking bench for the waveform marker output logic.
// Assumes the package, the marker block and the event listener are compiled first.
`timescale 1ns/100ps
`include "wml_consts.svh"
module waveform_marker_output_logic_test;
  logic                   i_clk, o_hold, o_blank, o_edit_refused, o_busy;
  logic                   i_sys_rst = 1'h1, i_play = 1'h0, i_gen_mode = 1'h1, i_seg_volatile = 1'h1;
  logic                   i_dl_we = 1'h0, i_mk_edit = 1'h0, i_mk_on = 1'h1, i_cfg_we = 1'h0, lis_clear = 1'h1;
  logic                   i_seq_we = 1'h0, i_seq_commit = 1'h0, i_seq_exit = 1'h0;
  wml_pkg::wml_cmd_t      i_cmd = wml_pkg::WML_CMD_NONE;
  logic [`WML_AW-1:0]     i_cmd_addr = 8'h00, i_dl_addr = 8'h00, i_mk_first = 8'h00, i_mk_last = 8'h00;
  logic [`WML_DW-1:0]     i_dl_data = 16'h0000, o_sample, o_level;
  logic [1:0]             i_mk_chan = 2'h0;
  logic [`WML_NMARK-1:0]  i_pol_neg = 4'h0, i_mk_en = 4'h0, o_event;
  logic [1:0]             i_route [`WML_NMARK] = '{default: 2'h0};
  logic [`WML_SEQ_AW-1:0] i_seq_idx = 4'h0, i_seq_rd_idx = 4'h0;
  logic [`WML_REP_W-1:0]  i_seq_rep = 16'h0000, o_seq_rep;
  int                     bad_count = 0, cmp_count = 0, pulses [`WML_NMARK];
  int                     vol = 0, nv = 0, cfg_neg = 0, cfg_rt = 0, vd = 0, nd = 0, lvl = 0;
  integer                 seed = 32'hb67d;

  // Sample clock, 4 ns period
  initial begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end

  wml_top u_wml_top (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_play(i_play), .i_gen_mode(i_gen_mode),
    .i_seg_volatile(i_seg_volatile), .i_cmd(i_cmd), .i_cmd_addr(i_cmd_addr), .i_dl_we(i_dl_we),
    .i_dl_addr(i_dl_addr), .i_dl_data(i_dl_data), .i_mk_edit(i_mk_edit), .i_mk_chan(i_mk_chan),
    .i_mk_first(i_mk_first), .i_mk_last(i_mk_last), .i_mk_on(i_mk_on), .i_pol_neg(i_pol_neg),
    .i_mk_en(i_mk_en), .i_route(i_route), .i_cfg_we(i_cfg_we), .i_seq_we(i_seq_we), .i_seq_idx(i_seq_idx),
    .i_seq_rep(i_seq_rep), .i_seq_commit(i_seq_commit), .i_seq_exit(i_seq_exit),
    .i_seq_rd_idx(i_seq_rd_idx), .o_seq_rep(o_seq_rep), .o_sample(o_sample), .o_event(o_event),
    .o_hold(o_hold), .o_blank(o_blank), .o_level(o_level), .o_edit_refused(o_edit_refused), .o_busy(o_busy)
  );
  wml_event_listener u_wml_event_listener (.i_clk(i_clk), .i_clear(lis_clear), .i_event(o_event), .o_pulses(pulses));

  // Verdict and end of run, also reached when a wait runs out
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare of bench counts and of design words
  task automatic cmp_int(input string what, input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("ERROR %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic cmp_word(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Edit attempt on word 0 of channel 0; the refusal flag is combinational
  task automatic try_edit(input logic vol_in, input logic gen, input logic exp);
    @(negedge i_clk);
    i_seg_volatile = vol_in;
    i_gen_mode = gen;
    i_mk_edit = 1'h1;
    #1 cmp_word("edit refused", {15'h0000, o_edit_refused}, {15'h0000, exp});
    @(negedge i_clk);
    i_mk_edit = 1'h0;
    i_seg_volatile = 1'h1;
  endtask

  // One command, then a bounded wait for the store engine to go idle
  task automatic do_cmd(input wml_pkg::wml_cmd_t c);
    int n;
    @(negedge i_clk);
    i_cmd = c;
    @(negedge i_clk);
    i_cmd = wml_pkg::WML_CMD_NONE;
    cmp_word("busy after command", {15'h0000, o_busy}, 16'h0001);
    n = 0;
    while (o_busy !== 1'h0 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
      $display("ERROR %0t busy never fell", $time);
      report_and_stop();
    end
    // Reference marker bits of word 0, the only word that any init marks
    case (c)
      wml_pkg::WML_CMD_INIT_GEN: begin
        vol = 3;
        vd = 0;
      end
      wml_pkg::WML_CMD_INIT_DL: begin
        vol = 0;
        vd = 0;
      end
      wml_pkg::WML_CMD_INIT_FACT: begin
        vol = 15;
        vd = 0;
      end
      wml_pkg::WML_CMD_STORE_ALL, wml_pkg::WML_CMD_STORE_ONE: begin
        nv = vol;
        nd = vd;
      end
      default: begin
        vol = nv;
        vd = nd;
      end
    endcase
  endtask

  // Download of one sample; its marker bits come back empty
  task automatic dl_word(input logic [7:0] a);
    @(negedge i_clk);
    i_dl_we = 1'h1;
    i_dl_addr = a;
    i_dl_data = $random(seed);
    @(negedge i_clk);
    i_dl_we = 1'h0;
    if (a == 8'h00) begin
      vol = 0;
      vd = i_dl_data;
    end
  endtask

  // Shadow edit of a repetition count, then stored or dropped
  task automatic seq_edit(input logic keep, input logic [3:0] idx);
    logic [15:0] r;
    r = $random(seed);
    @(negedge i_clk);
    i_seq_we = 1'h1;
    i_seq_idx = idx;
    i_seq_rep = r;
    @(negedge i_clk);
    i_seq_we = 1'h0;
    i_seq_commit = keep;
    i_seq_exit = !keep;
    @(negedge i_clk);
    i_seq_commit = 1'h0;
    i_seq_exit = 1'h0;
    i_seq_rd_idx = idx;
    #1 cmp_word("repetition count", o_seq_rep, keep ? r : 16'h0001);
  endtask

  // A full pass of 256 samples; hold and blank samples counted one cycle after each read
  task automatic play_pass(input logic [3:0] en, input logic neg, input logic [1:0] rt, input logic cfg);
    int nh = 0;
    int nb = 0;
    int eh;
    logic pd = 1'h0;
    @(negedge i_clk);
    i_mk_en = en;
    i_pol_neg = {3'h0, neg};
    i_route[0] = rt;
    i_cfg_we = cfg;
    lis_clear = 1'h1;
    if (cfg) begin
      cfg_neg = neg;
      cfg_rt = rt;
    end
    for (int i = 0; i < 260; i++) begin
      @(negedge i_clk);
      i_cfg_we = 1'h0;
      lis_clear = 1'h0;
      // Word 0 leaves the sample port two cycles after its read
      if (i == 2) cmp_word("sample", o_sample, 16'(vd));
      if (pd) begin
        nh += (o_hold === 1'h1);
        nb += (o_blank === 1'h1);
      end
      pd = (i < 256);
      i_play = pd;
    end
    // A marked word gives one high sample; negative polarity gives the other 255
    eh = (cfg_rt == 0) ? 0 : (vol[0] ? (cfg_neg ? 255 : 1) : (cfg_neg ? 256 : 0));
    cmp_int("hold samples", nh, eh);
    cmp_int("blank samples", nb, (cfg_rt == 2) ? eh : 0);
    for (int k = 0; k < 4; k++) cmp_int("event pulses", pulses[k], (en[k] && vol[k]) ? 1 : 0);
    // Only word 0 carries nonzero data, so the average is its share
    if (eh > 0) lvl = ((vol[0] ^ cfg_neg) ? vd : 0) / eh;
    cmp_word("level", o_level, 16'(lvl));
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge i_clk);
    i_sys_rst = 1'h0;
    for (int i = 0; i < 16; i++) begin
      @(negedge i_clk);
      i_seq_rd_idx = 4'(i);
      #1 cmp_word("repetition after reset", o_seq_rep, 16'h0001);
    end
    seq_edit(1'h0, 4'h3);
    seq_edit(1'h1, 4'h3);
    try_edit(1'h1, 1'h1, 1'h1);
    try_edit(1'h1, 1'h0, 1'h0);
    try_edit(1'h0, 1'h0, 1'h1);
    do_cmd(wml_pkg::WML_CMD_INIT_GEN);
    play_pass(4'hf, 1'h0, wml_pkg::WML_ROUTE_HOLD, 1'h1);
    try_edit(1'h1, 1'h1, 1'h0);
    do_cmd(wml_pkg::WML_CMD_INIT_FACT);
    play_pass(4'h5, 1'h0, wml_pkg::WML_ROUTE_BLANK, 1'h1);
    dl_word(8'h00);
    play_pass(4'hf, 1'h1, wml_pkg::WML_ROUTE_BLANK, 1'h1);
    do_cmd(wml_pkg::WML_CMD_INIT_FACT);
    do_cmd(wml_pkg::WML_CMD_STORE_ALL);
    do_cmd(wml_pkg::WML_CMD_INIT_DL);
    play_pass(4'hf, 1'h1, wml_pkg::WML_ROUTE_HOLD, 1'h1);
    do_cmd(wml_pkg::WML_CMD_LOAD_ALL);
    play_pass(4'hf, 1'h1, wml_pkg::WML_ROUTE_HOLD, 1'h0);
    play_pass(4'hf, 1'h0, wml_pkg::WML_ROUTE_BLANK, 1'h0);
    do_cmd(wml_pkg::WML_CMD_INIT_GEN);
    do_cmd(wml_pkg::WML_CMD_LOAD_ONE);
    play_pass(4'hf, 1'h0, wml_pkg::WML_ROUTE_HOLD, 1'h1);
    do_cmd(wml_pkg::WML_CMD_INIT_GEN);
    do_cmd(wml_pkg::WML_CMD_STORE_ONE);
    do_cmd(wml_pkg::WML_CMD_INIT_FACT);
    do_cmd(wml_pkg::WML_CMD_LOAD_ALL);
    play_pass(4'hf, 1'h0, wml_pkg::WML_ROUTE_HOLD, 1'h0);
    report_and_stop();
  end
endmodule
